/* epiu_pkg.sv */
// package of shared constants and types, plus the pointer arithmetic leaf.
// assumes a single core clock where each rising edge ends one instruction cycle.
`timescale 1ns/100ps
`default_nettype none
package epiu_pkg;
  localparam int ADDR_W = 12;
  localparam int PC_W   = 21;
  // opcode upper bytes of the extension
  localparam logic [7:0]  OP_PTR_ADD  = 8'h00_E8;
  localparam logic [7:0]  OP_PTR_SUB  = 8'h00_E9;
  localparam logic [7:0]  OP_PUSH_LIT = 8'h00_EA;
  localparam logic [7:0]  OP_MOVE_IDX = 8'h00_EB;
  localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
  localparam logic [3:0]  OP_SECOND_WORD = 4'hF;
  localparam logic [1:0]  SEL_FRAME_RET = 2'h3;
  localparam logic [1:0]  SEL_FRAME     = 2'h2;
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  // indexed window for standard byte and bit instructions
  localparam logic [7:0]  IDX_WINDOW_TOP = 8'h5F;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
  // indirect-access register groups: top address of each, four bytes below
  localparam logic [11:0] IND_TOP0 = 12'hFEF;
  localparam logic [11:0] IND_TOP1 = 12'hFE7;
  localparam logic [11:0] IND_TOP2 = 12'hFDF;
  localparam logic [11:0] IND_SPAN = 12'h004;
  localparam logic [7:0]  IND_READ_VALUE = 8'h00;
  // reset values
  localparam logic [11:0] PTR_RESET = 12'h000;
  localparam logic        EXT_RESET = 1'b1;
  localparam logic [1:0]  STRAP_SETTLE = 2'h3;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } epiu_mem_write_t;

  typedef struct packed {
    logic            valid;
    logic [PC_W-1:0] target;
  } epiu_pc_req_t;
endpackage

module epiu_ptr_arith (
  input  wire logic [11:0] base,
  input  wire logic [7:0]  literal,
  input  wire logic        subtract,
  output logic      [11:0] result
);
  // wraps modulo the data space, no flag
  assign result = subtract ? base - {4'h0, literal} : base + {4'h0, literal};
endmodule // epiu_ptr_arith
`default_nettype wire

/* epiu_unit.sv */
// decode and execute of the pointer extension instructions.
// assumes: one instruction per core_clk rising edge on instrWord when instrValid,
// memory read data returns one cycle after memRdAddr, core honours pcReq.
// Notes on behaviour
// RULE_01 - extension active when unprogrammed; config strap selects enable.
// RULE_02 - pointer add: 6-bit literal to chosen pointer, one cycle, flags untouched.
// RULE_03 - add with select 11 adds to frame pointer then returns from stack top.
// RULE_04 - frame add and return takes two cycles, second is idle.
// RULE_05 - call through working register pushes pc plus 2 first.
// RULE_06 - then pc low from working register, high and upper from latches.
// RULE_07 - call through working register takes two cycles, second idle.
// RULE_08 - call through working register leaves working, status, bank registers alone.
// RULE_09 - indexed-to-register move reads frame plus offset, writes 12-bit address.
// RULE_10 - two words, two cycles: read in first, write in second.
// RULE_11 - software never targets pc low byte or stack top bytes.
// RULE_12 - indexed source at an indirect register reads as 00h.
// RULE_13 - move addresses may lie anywhere in 000h to FFFh.
// RULE_14 - push literal stores at frame pointer then decrements it, one cycle.
// RULE_15 - pointer subtract: 6-bit literal from chosen pointer, one cycle.
// RULE_16 - subtract with select 11 uses frame pointer, returns, two cycles.
// RULE_17 - indexed-to-indexed move; indirect destination makes it a no-op.
// RULE_18 - enabled, access bit 0, argument up to 5Fh indexes frame pointer.
// RULE_19 - pointer results wrap modulo 4096.
`timescale 1ns/100ps
`default_nettype none
module epiu_unit (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    cfgExtEnablePin,
  input  wire logic                    instrValid,
  input  wire logic [15:0]             instrWord,
  input  wire logic [epiu_pkg::PC_W-1:0] pcCurrent,
  input  wire logic [7:0]              workingRegister,
  input  wire logic [7:0]              pcHighLatch,
  input  wire logic [4:0]              pcUpperLatch,
  input  wire logic [epiu_pkg::PC_W-1:0] topOfReturnStack,
  input  wire logic [7:0]              memRdData,
  input  wire logic [7:0]              stdFileArg,
  input  wire logic                    stdAccessBit,
  input  wire logic [3:0]              bankSelectRegister,
  output logic                         extEnabled,
  output logic [2:0][11:0]             filePtr,
  output logic [11:0]                  memRdAddr,
  output logic                         memRdEn,
  output epiu_pkg::epiu_mem_write_t    memWrite,
  output epiu_pkg::epiu_pc_req_t       pcReq,
  output logic                         stackPush,
  output logic [epiu_pkg::PC_W-1:0]    stackPushValue,
  output logic                         nopCycle,
  output logic [11:0]                  stdMappedAddr
);
  import epiu_pkg::*;

  typedef enum logic [1:0] {ST_DECODE, ST_IDLE2, ST_MOVE2} epiu_state_t;
  epiu_state_t state;

  logic [2:0]  strapSync;
  logic [1:0]  strapCount;
  logic        strapTaken;
  logic [7:0]  opHigh;
  logic [1:0]  sel;
  logic [7:0]  lit6;
  logic        isAdd;
  logic        isSub;
  logic        isPush;
  logic        isMove;
  logic        isCall;
  logic        moveToIndexed;
  logic [11:0] selPtrNext;
  logic [11:0] frameDec;
  logic [11:0] srcAddr;
  logic [11:0] dstIdxAddr;
  logic [11:0] stdIdxAddr;
  logic [11:0] moveDest;
  logic        moveDestOk;

  assign opHigh = instrWord[15:8];
  assign sel    = instrWord[7:6];
  assign lit6   = {2'b00, instrWord[5:0]};
  assign isAdd  = instrValid && extEnabled && state == ST_DECODE && opHigh == OP_PTR_ADD;
  assign isSub  = instrValid && extEnabled && state == ST_DECODE && opHigh == OP_PTR_SUB;
  assign isPush = instrValid && extEnabled && state == ST_DECODE && opHigh == OP_PUSH_LIT;
  assign isMove = instrValid && extEnabled && state == ST_DECODE && opHigh == OP_MOVE_IDX;
  assign isCall = instrValid && extEnabled && state == ST_DECODE && instrWord == OP_CALL_WORKING_REGISTER;

  function automatic logic isIndirect(input logic [11:0] a);
    isIndirect = (a <= IND_TOP0 && a >= IND_TOP0 - IND_SPAN) ||
                 (a <= IND_TOP1 && a >= IND_TOP1 - IND_SPAN) ||
                 (a <= IND_TOP2 && a >= IND_TOP2 - IND_SPAN);
  endfunction

  // RULE_19 wrapping pointer math
  epiu_ptr_arith uSelPtr (
    .base     (sel == SEL_FRAME_RET ? filePtr[SEL_FRAME] : filePtr[sel]),
    .literal  (lit6),
    .subtract (opHigh == OP_PTR_SUB),
    .result   (selPtrNext)
  );
  epiu_ptr_arith uFrameDec (
    .base     (filePtr[SEL_FRAME]),
    .literal  (8'h01),
    .subtract (1'b1),
    .result   (frameDec)
  );
  epiu_ptr_arith uSrcAddr (
    .base     (filePtr[SEL_FRAME]),
    .literal  ({1'b0, instrWord[6:0]}),
    .subtract (1'b0),
    .result   (srcAddr)
  );
  epiu_ptr_arith uDstAddr (
    .base     (filePtr[SEL_FRAME]),
    .literal  ({1'b0, instrWord[6:0]}),
    .subtract (1'b0),
    .result   (dstIdxAddr)
  );
  epiu_ptr_arith uStdAddr (
    .base     (filePtr[SEL_FRAME]),
    .literal  (stdFileArg),
    .subtract (1'b0),
    .result   (stdIdxAddr)
  );

  // RULE_01 strap sync, taken once when the last two stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strapSync  <= 3'b111;
      strapCount <= 2'h0;
      strapTaken <= 1'b0;
      extEnabled <= EXT_RESET;
    end else begin
      strapSync <= {strapSync[1:0], cfgExtEnablePin};
      if (strapCount != STRAP_SETTLE) begin
        strapCount <= strapCount + 2'h1;
      end else if (!strapTaken && strapSync[1] == strapSync[2]) begin
        // nonvolatile setting: later pin moves are ignored until reset
        strapTaken <= 1'b1;
        extEnabled <= strapSync[2];
      end
    end
  end

  // sequencing of the two-cycle forms
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_DECODE;
      nopCycle <= 1'b0;
    end else begin
      // RULE_04 / RULE_07 / RULE_16 flag the flushed second cycle
      nopCycle <= ((isAdd || isSub) && sel == SEL_FRAME_RET) || isCall;
      case (state)
        ST_DECODE: begin
          // RULE_04 / RULE_07 / RULE_16 second cycle idle
          if (((isAdd || isSub) && sel == SEL_FRAME_RET) || isCall) begin
            state <= ST_IDLE2;
          // RULE_10 wait for the second word
          end else if (isMove) begin
            state <= ST_MOVE2;
          end
        end
        ST_IDLE2: state <= ST_DECODE;
        ST_MOVE2: state <= instrValid ? ST_DECODE : ST_MOVE2;
        default: state <= ST_DECODE;
      endcase
    end
  end

  // pointer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      filePtr <= {3{PTR_RESET}};
    end else if (isAdd || isSub) begin
      // RULE_02 / RULE_15 / RULE_03 / RULE_16 select 11 hits frame only
      if (sel == SEL_FRAME_RET) begin
        filePtr[SEL_FRAME] <= selPtrNext;
      end else begin
        filePtr[sel] <= selPtrNext;
      end
    end else if (isPush) begin
      // RULE_14 decrement after store
      filePtr[SEL_FRAME] <= frameDec;
    end
  end

  // RULE_03 / RULE_06 program counter loads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pcReq <= '0;
    end else if ((isAdd || isSub) && sel == SEL_FRAME_RET) begin
      pcReq <= '{valid: 1'b1, target: topOfReturnStack};
    end else if (isCall) begin
      // RULE_08 pc loads and return address is pushed; working, status and bank untouched
      pcReq <= '{valid: 1'b1, target: {pcUpperLatch, pcHighLatch, workingRegister}};
    end else begin
      pcReq <= '0;
    end
  end

  // RULE_05 return address push
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stackPush      <= 1'b0;
      stackPushValue <= '0;
    end else begin
      stackPush      <= isCall;
      stackPushValue <= isCall ? pcCurrent + PC_STEP : stackPushValue;
    end
  end

  // RULE_09 / RULE_13 source read in the first cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memRdEn       <= 1'b0;
      memRdAddr     <= PTR_RESET;
      moveToIndexed <= 1'b0;
    end else begin
      memRdEn <= isMove;
      if (isMove) begin
        memRdAddr     <= srcAddr;
        moveToIndexed <= instrWord[7];
      end
    end
  end

  // RULE_09 / RULE_17 destination of the second word
  assign moveDest   = moveToIndexed ? dstIdxAddr : instrWord[11:0];
  assign moveDestOk = instrWord[15:12] == OP_SECOND_WORD &&
                      !(moveToIndexed && isIndirect(dstIdxAddr));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memWrite <= '0;
    end else if (isPush) begin
      // RULE_14 literal stored at the old frame pointer
      memWrite <= '{valid: 1'b1, addr: filePtr[SEL_FRAME], data: instrWord[7:0]};
    end else if (state == ST_MOVE2 && instrValid && moveDestOk) begin
      // RULE_12 indirect source reads as zero
      memWrite <= '{valid: 1'b1, addr: moveDest,
                    data: isIndirect(memRdAddr) ? IND_READ_VALUE : memRdData};
    end else begin
      memWrite <= '0;
    end
  end

  // RULE_18 address mapping for standard byte and bit instructions
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stdMappedAddr <= PTR_RESET;
    end else if (stdAccessBit) begin
      stdMappedAddr <= {bankSelectRegister, stdFileArg};
    end else if (extEnabled && stdFileArg <= IDX_WINDOW_TOP) begin
      stdMappedAddr <= stdIdxAddr;
    end else if (stdFileArg[7]) begin
      stdMappedAddr <= {ACCESS_HIGH_BANK, stdFileArg};
    end else begin
      stdMappedAddr <= {4'h0, stdFileArg};
    end
  end

  a_add_ptr0: assert property (@(posedge core_clk) disable iff (rst) // RULE_02
    isAdd && sel == 2'h0 |=> filePtr[0] == $past(filePtr[0]) + 12'($past(instrWord[5:0])))
    else $error("pointer add result wrong");
  a_sub_ptr1: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    isSub && sel == 2'h1 |=> filePtr[1] == $past(filePtr[1]) - 12'($past(instrWord[5:0])))
    else $error("pointer subtract result wrong");
  a_frame_return: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    isAdd && sel == SEL_FRAME_RET |=> pcReq.valid && pcReq.target == $past(topOfReturnStack)
      && filePtr[0] == $past(filePtr[0]))
    else $error("frame add did not return");
  a_frame_idle: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    (isAdd || isSub) && sel == SEL_FRAME_RET |=> state == ST_IDLE2 ##1 state == ST_DECODE)
    else $error("frame return not two cycles");
  a_call_push: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    isCall |=> stackPush && stackPushValue == $past(pcCurrent) + PC_STEP)
    else $error("call push value wrong");
  a_call_target: assert property (@(posedge core_clk) disable iff (rst) // RULE_06
    isCall |=> pcReq.target == {$past(pcUpperLatch), $past(pcHighLatch), $past(workingRegister)})
    else $error("call target wrong");
  a_call_nop: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    isCall |=> nopCycle && !memWrite.valid ##1 !pcReq.valid)
    else $error("call second cycle not idle");
  a_push_store: assert property (@(posedge core_clk) disable iff (rst) // RULE_14
    isPush |=> memWrite.valid && memWrite.addr == $past(filePtr[2])
      && filePtr[2] == $past(filePtr[2]) - 12'h001)
    else $error("push literal wrong");
  a_move_two: assert property (@(posedge core_clk) disable iff (rst) // RULE_10
    isMove |=> memRdEn && memRdAddr == $past(srcAddr) && !memWrite.valid)
    else $error("move read phase wrong");
  a_move_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE_12
    state == ST_MOVE2 && instrValid && moveDestOk && isIndirect(memRdAddr)
      |=> memWrite.valid && memWrite.data == IND_READ_VALUE)
    else $error("indirect source not zero");
  a_std_index: assert property (@(posedge core_clk) disable iff (rst) // RULE_18
    extEnabled && !stdAccessBit && stdFileArg <= IDX_WINDOW_TOP
      |=> stdMappedAddr == $past(filePtr[2]) + 12'($past(stdFileArg)))
    else $error("indexed mapping wrong");
endmodule // epiu_unit
`default_nettype wire

/* epiu_mem_model.sv */
// data memory model facing the pointer extension unit.
// assumes registered read requests; read data is settled mid-cycle for the next edge.
`timescale 1ns/100ps
`default_nettype none
module epiu_mem_model
  import epiu_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            memRdEn,
  input  wire logic [11:0]     memRdAddr,
  input  wire epiu_mem_write_t memWrite,
  output logic [7:0]           memRdData
);
  logic [7:0] mem [4096];

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i * 7 + 3);
    end
  end

  always @(posedge core_clk) begin
    if (memWrite.valid === 1'b1) begin
      mem[memWrite.addr] <= memWrite.data;
    end
  end

  // no read pending: data toggles so a stale byte never looks valid
  always @(negedge core_clk) begin
    memRdData <= (memRdEn === 1'b1) ? mem[memRdAddr] : ~memRdData;
  end
endmodule // epiu_mem_model
`default_nettype wire

/* test_extended_pointer_instruction_unit.sv */
// self-checking bench for the pointer extension unit.
// assumes epiu_pkg, epiu_unit and epiu_mem_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_extended_pointer_instruction_unit;
  import epiu_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              cfgExtEnablePin = 1'b1;
  logic              instrValid = 1'b0;
  logic              stdAccessBit = 1'b0;
  logic [15:0]       instrWord = 16'h0000;
  logic [PC_W-1:0]   pcCurrent = '0;
  logic [PC_W-1:0]   topOfReturnStack = '0;
  logic [7:0]        workingRegister = 8'h00;
  logic [7:0]        pcHighLatch = 8'h00;
  logic [7:0]        stdFileArg = 8'h00;
  logic [4:0]        pcUpperLatch = 5'h00;
  logic [3:0]        bankSelectRegister = 4'h0;
  logic [7:0]        memRdData;
  logic              extEnabled, memRdEn, stackPush, nopCycle;
  logic [2:0][11:0]  filePtr;
  logic [11:0]       memRdAddr, stdMappedAddr;
  logic [PC_W-1:0]   stackPushValue;
  epiu_mem_write_t   memWrite;
  epiu_pc_req_t      pcReq;
  logic [11:0]       fp [3] = '{12'h000, 12'h000, 12'h000};
  logic [35:0]       notes [$];
  int                n_mismatch = 0;
  int                compares = 0;

  epiu_unit i_epiu_unit (.core_clk, .rst, .cfgExtEnablePin, .instrValid, .instrWord,
    .pcCurrent, .workingRegister, .pcHighLatch, .pcUpperLatch, .topOfReturnStack,
    .memRdData, .stdFileArg, .stdAccessBit, .bankSelectRegister, .extEnabled, .filePtr,
    .memRdAddr, .memRdEn, .memWrite, .pcReq, .stackPush, .stackPushValue, .nopCycle,
    .stdMappedAddr);
  epiu_mem_model i_epiu_mem_model (.core_clk, .memRdEn, .memRdAddr, .memWrite, .memRdData);

  always #2.5 core_clk = ~core_clk;

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic issue(input logic [15:0] w);
    instrWord = w;
    instrValid = 1'b1;
    @(negedge core_clk);
  endtask

  task automatic idle(input int n);
    instrValid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk_ptr();
    for (int i = 0; i < 3; i++) begin
      check(filePtr[i], fp[i], "pointer");
    end
  endtask

  // walks the frame pointer to t with literal adds
  task automatic set_fp(input logic [11:0] t);
    logic [11:0] dlt;
    logic [5:0]  k;
    dlt = t - fp[2];
    while (dlt != 12'h000) begin
      k = (dlt > 12'h03F) ? 6'h3F : dlt[5:0];
      issue({OP_PTR_ADD, SEL_FRAME, k});
      fp[2] = fp[2] + k;
      dlt = dlt - k;
    end
  endtask

  function automatic logic is_ind(input logic [11:0] a);
    return (a >= 12'hFEB && a <= 12'hFEF) || (a >= 12'hFE3 && a <= 12'hFE7) ||
           (a >= 12'hFDB && a <= 12'hFDF);
  endfunction

  task automatic move(input logic [11:0] f, input logic to_idx, input logic [6:0] z,
                      input logic [11:0] dst);
    logic [11:0] src, a;
    logic [7:0]  d;
    set_fp(f);
    src = fp[2] + z;
    d = is_ind(src) ? 8'h00 : i_epiu_mem_model.mem[src];
    a = to_idx ? fp[2] + dst[6:0] : dst;
    if (!(to_idx && is_ind(a))) begin
      notes.push_back({4'h1, 12'h000, a, d});
    end
    issue({OP_MOVE_IDX, to_idx, z});
    check(memRdEn, 1'b1, "read pulse");
    check(memRdAddr, src, "read address");
    issue({OP_SECOND_WORD, dst});
    idle(1);
  endtask

  task automatic map_chk(input logic a, input logic [7:0] f, input logic [11:0] exp);
    stdAccessBit = a;
    stdFileArg = f;
    @(negedge core_clk);
    check(stdMappedAddr, exp, "mapped address");
  endtask

  // results in issue order; a pulse with no note is itself a mismatch
  task automatic take(input logic [35:0] got);
    if (notes.size() == 0) begin
      compares++;
      n_mismatch++;
      $display("[ERR] %0t unexpected result %h", $time, got);
    end else begin
      check(got, notes.pop_front(), "result");
    end
  endtask

  always @(negedge core_clk) begin
    if (rst === 1'b0) begin
      if (stackPush !== 1'b0) take({4'h3, 11'h000, stackPushValue});
      if (pcReq.valid !== 1'b0) take({4'h2, 11'h000, pcReq.target});
      if (memWrite.valid !== 1'b0) take({4'h1, 12'h000, memWrite.addr, memWrite.data});
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    print_verdict();
  end

  initial begin
    logic [1:0] sel;
    logic [5:0] k;
    logic [7:0] d;
    void'($urandom(32'hfd2e));
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    idle(3);
    check(extEnabled, 1'b1, "enable at reset");
    chk_ptr();
    for (int n = 0; n < 24; n++) begin
      sel = 2'($urandom_range(2, 0));
      k = 6'($urandom);
      issue({n[0] ? OP_PTR_SUB : OP_PTR_ADD, sel, k});
      fp[sel] = n[0] ? fp[sel] - k : fp[sel] + k;
      chk_ptr();
    end
    for (int n = 0; n < 2; n++) begin
      k = 6'($urandom);
      topOfReturnStack = 21'($urandom);
      notes.push_back({4'h2, 11'h000, topOfReturnStack});
      issue({n[0] ? OP_PTR_SUB : OP_PTR_ADD, SEL_FRAME_RET, k});
      fp[2] = n[0] ? fp[2] - k : fp[2] + k;
      check(nopCycle, 1'b1, "idle after return");
      // lands in the idle cycle, must be flushed
      issue({OP_PTR_ADD, 2'h0, 6'h3F});
      idle(1);
      chk_ptr();
    end
    pcCurrent = 21'($urandom);
    workingRegister = 8'($urandom);
    pcHighLatch = 8'($urandom);
    pcUpperLatch = 5'($urandom);
    notes.push_back({4'h3, 11'h000, pcCurrent + PC_STEP});
    notes.push_back({4'h2, 11'h000, pcUpperLatch, pcHighLatch, workingRegister});
    issue(OP_CALL_WORKING_REGISTER);
    check(nopCycle, 1'b1, "idle after call");
    idle(2);
    for (int n = 0; n < 3; n++) begin
      d = 8'($urandom);
      notes.push_back({4'h1, 12'h000, fp[2], d});
      issue({OP_PUSH_LIT, d});
      fp[2] = fp[2] - 12'h001;
    end
    idle(1);
    chk_ptr();
    // destinations avoid pc low byte and stack top bytes
    move(12'hFE0, 1'b0, 7'h0F, 12'hFF0);
    move(12'hF80, 1'b0, 7'h7F, 12'h000);
    move(12'h010, 1'b1, 7'h05, 12'h006);
    move(12'hFD0, 1'b1, 7'h01, 12'h013);
    map_chk(1'b0, 8'h5F, fp[2] + 12'h05F);
    map_chk(1'b0, 8'h60, 12'h060);
    map_chk(1'b0, 8'h80, 12'hF80);
    bankSelectRegister = 4'($urandom);
    map_chk(1'b1, 8'h34, {bankSelectRegister, 8'h34});
    // the strap is taken once after reset, so a new setting needs a reset
    cfgExtEnablePin = 1'b0;
    rst = 1'b1;
    idle(2);
    rst = 1'b0;
    fp = '{12'h000, 12'h000, 12'h000};
    idle(6);
    chk_ptr();
    check(extEnabled, 1'b0, "enable from strap");
    issue({OP_PTR_ADD, 2'h1, 6'h3F});
    idle(1);
    chk_ptr();
    map_chk(1'b0, 8'h10, 12'h010);
    for (int i = 0; i < 8 && notes.size() != 0; i++) @(negedge core_clk);
    check(notes.size(), 36'h0, "missing results");
    print_verdict();
  end
endmodule // test_extended_pointer_instruction_unit
`default_nettype wire
